/* File: hw/sideband_pkg.sv */
// Purpose: constants shared by the module sideband control block
// Assumes: pclk at 20 MHz; 2-wire bus sampled on pclk
// Notes:   Operation list below; tags appear in the design
//
// Operation
// - answer 2-wire traffic only while selected
// - long reset pulse restores all defaults
// - completion interrupt posted with not-ready cleared
// - power-up posts completion interrupt unprompted
// - undriven init control reads high
// - init control high: low power until enabled
// - init control low: high power after init
// - present line tied low while inserted
// - interrupt low flags fault or critical status
// - interrupt output is open collector
// - memory map reached over 2-wire bus
package sideband_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 50;
  localparam int unsigned RESET_MIN_NS     = 10000;
  localparam int unsigned RESET_MIN_CYC    = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INIT_NS          = 2000;
  localparam int unsigned INIT_CYC         = (INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // memory map and 2-wire address
  // ----------------------------------------------------------------
  localparam int unsigned MAP_DEPTH_DEF    = 64;
  localparam logic [6:0]  DEVICE_ADDR_DEF  = 7'h50;
  localparam logic [7:0]  MAP_STATUS_IDX   = 8'h00;
  localparam logic [7:0]  MAP_HOSTCTL_IDX  = 8'h01;
  localparam int unsigned MST_NOT_READY    = 0;
  localparam int unsigned MST_RESET_DONE   = 1;
  localparam int unsigned MST_FAULT        = 2;
  localparam int unsigned MST_HIGH_POWER   = 3;
  localparam int unsigned HCT_HP_ENABLE    = 0;

  // ----------------------------------------------------------------
  // apb registers
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFFSET      = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET    = 8'h04;
  localparam int unsigned CTRL_FAULT_POST  = 0;

  // ----------------------------------------------------------------
  // 2-wire bus states, gray along the usual path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TW_IDLE  = 3'b000,
    TW_ADDR  = 3'b001,
    TW_AACK  = 3'b011,
    TW_WR    = 3'b010,
    TW_WACK  = 3'b110,
    TW_RD    = 3'b111,
    TW_RACK  = 3'b101
  } tw_state_t;

endpackage

/* File: hw/module_sideband_control.sv */
// Purpose: sideband control of a pluggable module: select, reset, init mode,
//          present, interrupt, and a 2-wire slave onto the memory map
// Assumes: all pins asynchronous to pclk; scl slow against pclk
// Notes:   firmware reaches control/status over apb
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
module module_sideband_control #(
  parameter int unsigned RESET_MIN_CYCLES = sideband_pkg::RESET_MIN_CYC,
  parameter int unsigned INIT_CYCLES      = sideband_pkg::INIT_CYC,
  parameter int unsigned MAP_DEPTH        = sideband_pkg::MAP_DEPTH_DEF,
  parameter logic [6:0]  DEVICE_ADDR      = sideband_pkg::DEVICE_ADDR_DEF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        module_select_n,
  input  wire logic        module_reset_n,
  input  wire logic        init_control_select,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        interrupt_n_i,
  output logic             interrupt_n_o,
  output logic             interrupt_n_oe,
  output logic             module_present_n,
  output logic             high_power
);
  import sideband_pkg::*;

  localparam int unsigned PW = $clog2(MAP_DEPTH);

  if (MAP_DEPTH < 4 || MAP_DEPTH > 256 || (MAP_DEPTH & (MAP_DEPTH - 1)) != 0) begin : g_chk_depth
    $error("MAP_DEPTH must be a power of two from 4 to 256");
  end
  if (RESET_MIN_CYCLES < 1 || RESET_MIN_CYCLES > 65535 || INIT_CYCLES < 1 || INIT_CYCLES > 65535) begin : g_chk_cnt
    $error("cycle counts must lie in 1..65535");
  end

  // ----------------------------------------------------------------
  // pin synchronisers: {int, sda, scl, init, reset, select}
  // ----------------------------------------------------------------
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 6'h3F;
      sync2_reg <= 6'h3F;
    end else begin
      sync1_reg <= {interrupt_n_i, sda_i, scl_i, init_control_select, module_reset_n, module_select_n};
      sync2_reg <= sync1_reg;
    end
  end

  wire msel_n_s  = sync2_reg[0];
  wire rst_low   = ~sync2_reg[1];
  wire init_s    = sync2_reg[2];
  wire scl_s     = sync2_reg[3];
  wire sda_s     = sync2_reg[4];
  wire int_low_s = ~sync2_reg[5];

  // ----------------------------------------------------------------
  // module reset: pulse must outlast the minimum length
  // ----------------------------------------------------------------
  logic [15:0] rst_cnt_reg;
  wire         settings_clear = rst_low && (rst_cnt_reg == 16'(RESET_MIN_CYCLES));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rst_cnt_reg <= 16'h0000;
    else if (!rst_low)
      rst_cnt_reg <= 16'h0000;
    else if (!settings_clear)
      rst_cnt_reg <= rst_cnt_reg + 16'h0001;
  end

  // ----------------------------------------------------------------
  // management init timer, status flags, power mode
  // ----------------------------------------------------------------
  logic        not_ready_reg;
  logic [15:0] init_cnt_reg;
  logic        reset_done_reg;
  logic        fault_reg;
  logic        init_mode_reg;
  logic        high_power_reg;
  logic [7:0]  host_ctrl_reg;
  logic        status_read;
  logic        fault_post;

  wire done_set = not_ready_reg && !settings_clear && (init_cnt_reg == 16'(INIT_CYCLES - 1));
  wire hp_next  = !not_ready_reg && !settings_clear && (init_mode_reg ? host_ctrl_reg[HCT_HP_ENABLE] : 1'b1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      not_ready_reg <= 1'b1;
      init_cnt_reg  <= 16'h0000;
    end else if (settings_clear) begin
      not_ready_reg <= 1'b1;
      init_cnt_reg  <= 16'h0000;
    end else if (not_ready_reg) begin
      not_ready_reg <= !done_set;
      init_cnt_reg  <= init_cnt_reg + 16'h0001;
    end
  end

  // set wins over the clear-on-read of the status byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_done_reg <= 1'b0;
      fault_reg      <= 1'b0;
    end else begin
      reset_done_reg <= done_set || (reset_done_reg && !status_read && !settings_clear);
      fault_reg      <= fault_post || (fault_reg && !status_read && !settings_clear);
    end
  end

  // init level captured once per init; host must hold it steady
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      init_mode_reg <= 1'b1;
    else if (done_set)
      init_mode_reg <= init_s;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      high_power_reg <= 1'b0;
    else
      high_power_reg <= hp_next;
  end

  // ----------------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------------
  logic intr_oe_reg;
  logic sda_drive_reg;
  logic present_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intr_oe_reg <= 1'b0;
      present_reg <= 1'b0;
    end else begin
      intr_oe_reg <= (reset_done_reg || fault_reg) && !not_ready_reg;
      present_reg <= 1'b0;
    end
  end
  assign interrupt_n_o    = 1'b0;
  assign interrupt_n_oe   = intr_oe_reg;
  assign sda_o            = 1'b0;
  assign sda_oe           = sda_drive_reg;
  assign module_present_n = present_reg;
  assign high_power       = high_power_reg;

  // ----------------------------------------------------------------
  // 2-wire slave onto the memory map
  // ----------------------------------------------------------------
  tw_state_t  state_reg;
  logic       scl_prev_reg;
  logic       sda_prev_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic       byte_done_reg;
  logic       rw_reg;
  logic       first_reg;
  logic       nack_reg;
  logic [7:0] ptr_reg;
  logic [7:0] map_mem [MAP_DEPTH];

  wire scl_rise = scl_s && !scl_prev_reg;
  wire scl_fall = !scl_s && scl_prev_reg;
  wire start_c  = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
  wire stop_c   = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;
  wire selected = !msel_n_s;
  wire addr_hit = (shift_reg[7:1] == DEVICE_ADDR);
  wire [7:0] status_byte = {4'h0, high_power_reg, fault_reg, reset_done_reg, not_ready_reg};
  wire [7:0] rd_byte = (ptr_reg == MAP_STATUS_IDX)  ? status_byte :
                       (ptr_reg == MAP_HOSTCTL_IDX) ? host_ctrl_reg : map_mem[ptr_reg[PW-1:0]];
  wire load_rd  = scl_fall && ((state_reg == TW_AACK && rw_reg) || (state_reg == TW_RACK && !nack_reg));
  wire wr_byte  = scl_fall && state_reg == TW_WR && byte_done_reg && !first_reg;
  assign status_read = load_rd && (ptr_reg == MAP_STATUS_IDX);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= TW_IDLE;
      sda_drive_reg <= 1'b0;
      shift_reg     <= 8'h00;
      bit_cnt_reg   <= 3'h0;
      byte_done_reg <= 1'b0;
      rw_reg        <= 1'b0;
      first_reg     <= 1'b0;
      nack_reg      <= 1'b0;
      ptr_reg       <= 8'h00;
    end else if (!selected || settings_clear || stop_c) begin
      state_reg     <= TW_IDLE;
      sda_drive_reg <= 1'b0;
    end else if (start_c) begin
      state_reg     <= TW_ADDR;
      sda_drive_reg <= 1'b0;
      bit_cnt_reg   <= 3'h0;
      byte_done_reg <= 1'b0;
    end else if (scl_rise) begin
      case (state_reg)
        TW_ADDR, TW_WR: begin
          shift_reg     <= {shift_reg[6:0], sda_s};
          bit_cnt_reg   <= bit_cnt_reg + 3'h1;
          byte_done_reg <= (bit_cnt_reg == 3'h7);
        end
        TW_RD: begin
          bit_cnt_reg   <= bit_cnt_reg + 3'h1;
          byte_done_reg <= (bit_cnt_reg == 3'h7);
        end
        TW_RACK: nack_reg <= sda_s;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (state_reg)
        TW_ADDR: if (byte_done_reg) begin
          state_reg     <= addr_hit ? TW_AACK : TW_IDLE;
          sda_drive_reg <= addr_hit;
          rw_reg        <= shift_reg[0];
          first_reg     <= 1'b1;
        end
        TW_WR: if (byte_done_reg) begin
          state_reg     <= TW_WACK;
          sda_drive_reg <= 1'b1;
          first_reg     <= 1'b0;
          ptr_reg       <= first_reg ? shift_reg : ptr_reg + 8'h01;
        end
        TW_AACK, TW_WACK: begin
          bit_cnt_reg   <= 3'h0;
          byte_done_reg <= 1'b0;
          state_reg     <= (state_reg == TW_AACK && rw_reg) ? TW_RD : TW_WR;
          shift_reg     <= rd_byte;
          sda_drive_reg <= (state_reg == TW_AACK && rw_reg) ? !rd_byte[7] : 1'b0;
        end
        TW_RD: begin
          if (byte_done_reg) begin
            state_reg     <= TW_RACK;
            sda_drive_reg <= 1'b0;
            ptr_reg       <= ptr_reg + 8'h01;
          end else begin
            shift_reg     <= {shift_reg[6:0], 1'b0};
            sda_drive_reg <= !shift_reg[6];
          end
        end
        TW_RACK: begin
          state_reg     <= nack_reg ? TW_IDLE : TW_RD;
          shift_reg     <= rd_byte;
          bit_cnt_reg   <= 3'h0;
          byte_done_reg <= 1'b0;
          sda_drive_reg <= !nack_reg && !rd_byte[7];
        end
        default: state_reg <= TW_IDLE;
      endcase
    end
  end

  // map storage; a long reset returns every byte to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_ctrl_reg <= 8'h00;
      for (int i = 0; i < MAP_DEPTH; i++)
        map_mem[i] <= 8'h00;
    end else if (settings_clear) begin
      host_ctrl_reg <= 8'h00;
      for (int i = 0; i < MAP_DEPTH; i++)
        map_mem[i] <= 8'h00;
    end else if (wr_byte) begin
      if (ptr_reg == MAP_HOSTCTL_IDX)
        host_ctrl_reg <= shift_reg;
      else if (ptr_reg != MAP_STATUS_IDX)
        map_mem[ptr_reg[PW-1:0]] <= shift_reg;
    end
  end

  // ----------------------------------------------------------------
  // apb slave: one wait-free access phase
  // ----------------------------------------------------------------
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  wire setup_c  = psel && !penable;
  wire hit_ctrl = (paddr == CTRL_OFFSET);
  wire hit_stat = (paddr == STATUS_OFFSET);
  wire [31:0] status_word = {26'h0, int_low_s, selected, high_power_reg, init_mode_reg,
                             settings_clear, not_ready_reg};
  assign fault_post = psel && penable && pready_reg && pwrite && hit_ctrl && pwdata[CTRL_FAULT_POST];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= setup_c;
      prdata_reg  <= (setup_c && !pwrite && hit_stat) ? status_word : 32'h00000000;
      pslverr_reg <= setup_c && !(hit_ctrl || hit_stat);
    end
  end
  assign pready  = pready_reg;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence seq_init_done;
    done_set ##1 (reset_done_reg && !not_ready_reg);
  endsequence

  a_deselect_idle:    assert property (@(posedge pclk) disable iff (!presetn)
    msel_n_s |=> state_reg == TW_IDLE) else $error("slave active while deselected");
  a_deselect_release: assert property (@(posedge pclk) disable iff (!presetn)
    msel_n_s |=> !sda_oe) else $error("data line driven while deselected");
  a_reset_defaults:   assert property (@(posedge pclk) disable iff (!presetn)
    settings_clear |=> not_ready_reg && !high_power && host_ctrl_reg == 8'h00) else $error("reset left settings");
  a_done_irq:         assert property (@(posedge pclk) disable iff (!presetn)
    seq_init_done |=> interrupt_n_oe && !not_ready_reg) else $error("no completion interrupt");
  a_powerup_done:     assert property (@(posedge pclk) disable iff (!presetn)
    $fell(not_ready_reg) |-> reset_done_reg) else $error("completion flag missing");
  a_sw_low_power:     assert property (@(posedge pclk) disable iff (!presetn)
    init_mode_reg && !host_ctrl_reg[HCT_HP_ENABLE] |=> !high_power) else $error("high power without enable");
  a_hw_high_power:    assert property (@(posedge pclk) disable iff (!presetn)
    !not_ready_reg && !init_mode_reg && !settings_clear |=> high_power) else $error("hw mode not in high power");
  a_present_low:      assert property (@(posedge pclk) disable iff (!presetn)
    ##1 !module_present_n) else $error("present line not low");
  a_irq_cause:        assert property (@(posedge pclk) disable iff (!presetn)
    interrupt_n_oe |-> $past(reset_done_reg || fault_reg)) else $error("interrupt without cause");
  a_irq_pulldown:     assert property (@(posedge pclk) disable iff (!presetn)
    interrupt_n_oe |-> interrupt_n_o == 1'b0) else $error("interrupt drives high");
  a_addr_ack:         assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == TW_AACK |-> sda_oe) else $error("address not acknowledged");

endmodule  // module_sideband_control

/* File: verif/host_model.sv */
// Purpose: host board side of the 2-wire management bus
// Assumes: sda resolved outside with pull-up; 400 ns scl period
// Notes:   scl stands high outside frames
`timescale 1ns/1ps
module host_model (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda_line
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // start or repeated start
  task automatic start();
    sda_low = 1'b0;
    #100 scl = 1'b1;
    #100 sda_low = 1'b1;
    #100 scl = 1'b0;
    #100;
  endtask

  task automatic stop();
    sda_low = 1'b1;
    #100 scl = 1'b1;
    #100 sda_low = 1'b0;
    #200;
  endtask

  // one byte msb first plus ack bit; tx of FF releases the line for reads
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = !tx[i];
      #100 scl = 1'b1;
      #100 rx[i] = sda_line;
      #100 scl = 1'b0;
      #100;
    end
    sda_low = mack;
    #100 scl = 1'b1;
    #100 ack = !sda_line;
    #100 scl = 1'b0;
    #100 sda_low = 1'b0;
  endtask
endmodule // host_model

/* File: verif/module_sideband_control_tb.sv */
// Purpose: self-checking bench of the module sideband control block
// Assumes: short reset and init counts set by parameter
// Notes:   open-drain lines resolved here with pull-ups
`timescale 1ns/1ps
module module_sideband_control_tb;
  import sideband_pkg::*;
  localparam logic [7:0] AW = {DEVICE_ADDR_DEF, 1'b0};
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] rd; logic err;} row_t;
  localparam row_t ROWS [4] = '{'{1'b0, STATUS_OFFSET, 32'h24, 1'b0}, '{1'b0, CTRL_OFFSET, 32'h0, 1'b0},
                                '{1'b1, 8'h08, 32'h0, 1'b1}, '{1'b0, 8'h0C, 32'h0, 1'b1}};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sel_n = 1, mrst_n = 1, init_sel = 1;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, sda_o, sda_oe, int_o, int_oe, present_n, high_power, scl, h_low, err, ack;
  logic [7:0] b;
  int fail_count = 0, check_count = 0;
  wire sda_line = !(sda_oe | h_low);
  wire int_line = !int_oe;

  always #25 pclk = ~pclk;

  module_sideband_control #(.RESET_MIN_CYCLES(8), .INIT_CYCLES(4)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .module_select_n(sel_n),
    .module_reset_n(mrst_n), .init_control_select(init_sel), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .interrupt_n_i(int_line), .interrupt_n_o(int_o),
    .interrupt_n_oe(int_oe), .module_present_n(present_n), .high_power(high_power));
  host_model h (.scl(scl), .sda_low(h_low), .sda_line(sda_line));

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // request stands until ready is seen high at a rising edge; data taken at that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_int(input logic exp);
    int n = 0;
    while (int_oe !== exp && n < 200) begin
      @(posedge pclk);
      n++;
    end
    repeat (2) @(posedge pclk);
  endtask

  // host frames start on a falling clock edge so no pin moves on a sampling edge
  task automatic tw_probe(input logic [7:0] aw, output logic a);
    @(negedge pclk);
    h.start();
    h.xfer(aw, 1'b0, b, a);
    h.stop();
    @(posedge pclk);
  endtask

  task automatic tw_wr(input logic [7:0] p, input logic [7:0] d);
    logic a1, a2, a3;
    @(negedge pclk);
    h.start();
    h.xfer(AW, 1'b0, b, a1);
    h.xfer(p, 1'b0, b, a2);
    h.xfer(d, 1'b0, b, a3);
    h.stop();
    @(posedge pclk);
    chk("write acks", {a1, a2, a3}, 3'b111);
  endtask

  task automatic tw_rd(input logic [7:0] p, output logic [7:0] d);
    logic a1, a2, a3;
    @(negedge pclk);
    h.start();
    h.xfer(AW, 1'b0, b, a1);
    h.xfer(p, 1'b0, b, a2);
    h.start();
    h.xfer(AW | 8'h01, 1'b0, b, a3);
    h.xfer(8'hFF, 1'b0, d, ack);
    h.stop();
    @(posedge pclk);
    chk("read acks", {a1, a2, a3}, 3'b111);
  endtask

  initial begin
    repeat (40000) @(posedge pclk);
    fail_count++;
    test_done();
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    wait_int(1'b1);
    chk("int after powerup", int_oe, 1);
    chk("int pin level", int_o, 0);
    chk("sda pin level", sda_o, 0);
    chk("present", present_n, 0);
    chk("low power sw mode", high_power, 0);
    foreach (ROWS[i]) begin
      apb(ROWS[i].wr, ROWS[i].a, 32'h1);
      chk("apb rdata", rd, ROWS[i].rd);
      chk("apb err", err, ROWS[i].err);
    end
    $display("test apb table done");
    tw_probe(AW, ack);
    chk("deselected ack", ack, 0);
    chk("deselected sda", sda_oe, 0);
    sel_n <= 1'b0;
    repeat (4) @(posedge pclk);
    tw_probe(AW | 8'h02, ack);
    chk("wrong addr ack", ack, 0);
    tw_rd(MAP_STATUS_IDX, b);
    chk("status byte", b, 8'h02);
    wait_int(1'b0);
    chk("int cleared", int_oe, 0);
    apb(1'b1, CTRL_OFFSET, 32'h1);
    wait_int(1'b1);
    chk("fault int", int_oe, 1);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk("status line low", rd[5:4], 2'b11);
    tw_rd(MAP_STATUS_IDX, b);
    chk("fault byte", b, 8'h04);
    tw_wr(8'h02, 8'h5A);
    tw_rd(8'h02, b);
    chk("map byte", b, 8'h5A);
    tw_wr(MAP_HOSTCTL_IDX, 8'h01);
    repeat (4) @(posedge pclk);
    chk("sw enable", high_power, 1);
    $display("test 2-wire done");
    mrst_n <= 1'b0;
    repeat (4) @(posedge pclk);
    mrst_n <= 1'b1;
    repeat (20) @(posedge pclk);
    chk("short pulse", high_power, 1);
    mrst_n <= 1'b0;
    repeat (30) @(posedge pclk);
    chk("reset hp", high_power, 0);
    mrst_n <= 1'b1;
    wait_int(1'b1);
    chk("reset done int", int_oe, 1);
    tw_rd(8'h02, b);
    chk("map default", b, 8'h00);
    $display("test module reset done");
    presetn <= 1'b0;
    init_sel <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    wait_int(1'b1);
    repeat (4) @(posedge pclk);
    chk("hw mode hp", high_power, 1);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk("hw mode status", rd, 32'h38);
    $display("test hardware init done");
    test_done();
  end
endmodule // module_sideband_control_tb
